// ==== core/pmbs_defs.svh ====
// constants for the power-mode and boot-select block
// assumes inclusion by bare name from core/ sources
`ifndef PMBS_DEFS_SVH
`define PMBS_DEFS_SVH
`define PMBS_OFS_MODE     8'h00
`define PMBS_OFS_ANALOG   8'h04
`define PMBS_OFS_STATUS   8'h08
`define PMBS_OFS_WAKE     8'h0c
`define PMBS_MODE_NORMAL  2'h0
`define PMBS_MODE_IDLE    2'h1
`define PMBS_MODE_PDOWN   2'h2
`define PMBS_ANA_ADC      0
`define PMBS_ANA_DAC0     1
`define PMBS_ANA_DAC1     2
`define PMBS_ANA_VREF     3
`define PMBS_ANALOG_RST   4'h0
`define PMBS_STROBE_PERIOD 4'h6
`endif

// ==== core/pmbs_pkg.sv ====
// types for the power-mode and boot-select block
// assumes nothing of its surroundings
package pmbs_pkg;
  typedef enum logic [1:0] {
    PMBS_ST_RUN   = 2'b00,
    PMBS_ST_ARM   = 2'b01,
    PMBS_ST_IDLE  = 2'b11,
    PMBS_ST_PDOWN = 2'b10
  } pmbs_state_t;
  typedef struct packed {
    logic       adc_en;
    logic [1:0] dac_en;
    logic       vref_en;
  } pmbs_analog_t;
  typedef struct packed {
    logic       core_clk_en;
    logic       periph_clk_en;
    logic       osc_en;
    logic       hold_ports;
    logic       dac_hold;
    logic       dac_hiz;
  } pmbs_power_t;
endpackage

// ==== core/pmbs_strobe.sv ====
// program strobe generator for external code fetches
// assumes fetch_req is a level from the fetch unit, synchronous to hclk
`timescale 1ns/10ps
`default_nettype none
`include "pmbs_defs.svh"
module pmbs_strobe (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic enable,
  input  wire logic fetch_req,
  output var  logic strobe_n
);
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic       strobe_n_r;
  logic       active;
  // strobe low during the second half of each fetch slot
  assign active   = enable & fetch_req;
  assign cnt_nxt  = (!active || cnt_r == `PMBS_STROBE_PERIOD - 4'h1) ? 4'h0 : cnt_r + 4'h1;
  assign strobe_n = strobe_n_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r      <= 4'h0;
      strobe_n_r <= 1'b1;
    end else begin
      cnt_r      <= cnt_nxt;
      strobe_n_r <= !(active && cnt_nxt >= (`PMBS_STROBE_PERIOD >> 1));
    end
  end
endmodule
`default_nettype wire

// ==== core/pmbs_top.sv ====
// power-mode control, analog enables and reset-time boot select
// assumes a single AHB-Lite master, word accesses, and the core signals
// instr_done when the current instruction retires
//
// Behaviour
// - software selects normal, idle or power-down
// - idle keeps oscillator, gates core clock only
// - peripherals keep their clock in idle
// - idle holds port and converter output pins
// - enabled interrupt or reset leaves idle
// - power-down stops oscillator and all peripherals
// - power-down holds ports, tristates converter outputs
// - only reset leaves power-down, never interrupts
// - converters and reference individually disabled
// - reference forced on when any converter on
// - strobe pin output, sampled only at reset
// - strobe low at release selects download mode
// - strobe high at release runs user code
// - download mode readies serial port for program
// - debug mode shares the download entry condition
// - strobe pin strobes external code fetches
`timescale 1ns/10ps
`default_nettype none
`include "pmbs_defs.svh"
module pmbs_top (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output var  logic [31:0]           hrdata,
  output var  logic                  hreadyout,
  output var  logic                  hresp,
  input  wire logic                  instr_done,
  input  wire logic                  irq_pending,
  input  wire logic                  fetch_req,
  input  wire logic                  strobe_in,
  output var  logic                  strobe_out,
  output var  logic                  strobe_oe,
  output var  pmbs_pkg::pmbs_power_t power,
  output var  pmbs_pkg::pmbs_analog_t analog,
  output var  logic                  download_mode,
  output var  logic                  uart_loader_en
);
  import pmbs_pkg::*;

  pmbs_state_t  state_r;
  pmbs_state_t  state_nxt;
  logic [1:0]   req_mode_r;
  logic [3:0]   ana_r;
  logic         boot_taken_r;
  logic         download_r;
  logic         wake_irq_r;
  logic         wake_irq_nxt;
  logic         ph_wr_r;
  logic [7:0]   ph_addr_r;
  logic [31:0]  hrdata_r;
  pmbs_power_t  power_r;
  pmbs_power_t  power_nxt;
  pmbs_analog_t analog_r;
  pmbs_analog_t analog_nxt;
  logic         strobe_oe_r;
  logic         fetch_strobe_n;
  logic         addr_ok;
  logic         wr_mode;
  logic         wr_ana;
  logic         wr_wake;
  logic         idle_exit;
  logic [31:0]  rd_mux;
  logic         hreadyout_r;
  logic         hresp_r;

  // bus decode; only the slave's word registers, no wait states
  assign addr_ok = hsel & hready & htrans[1];
  assign wr_mode = ph_wr_r && ph_addr_r == `PMBS_OFS_MODE;
  assign wr_ana  = ph_wr_r && ph_addr_r == `PMBS_OFS_ANALOG;
  assign wr_wake = ph_wr_r && ph_addr_r == `PMBS_OFS_WAKE;

  // read mux, unmapped reads as zero
  assign rd_mux = (haddr[7:0] == `PMBS_OFS_MODE)   ? {30'h0, req_mode_r} :
                  (haddr[7:0] == `PMBS_OFS_ANALOG) ? {28'h0, ana_r} :
                  (haddr[7:0] == `PMBS_OFS_STATUS) ? {26'h0, analog_r.vref_en, download_r, 2'h0, state_r} :
                  (haddr[7:0] == `PMBS_OFS_WAKE)   ? {31'h0, wake_irq_r} : 32'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr_r   <= 1'b0;
      ph_addr_r <= 8'h00;
      hrdata_r  <= 32'h0;
    end else begin
      ph_wr_r   <= addr_ok & hwrite;
      ph_addr_r <= haddr[7:0];
      hrdata_r  <= (addr_ok && !hwrite) ? rd_mux : hrdata_r;
    end
  end
  assign hrdata    = hrdata_r;

  // response flops; the slave never stalls, but its outputs still leave from registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
    end else begin
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
    end
  end
  assign hreadyout = hreadyout_r;
  assign hresp     = hresp_r;

  // mode request and analog enables; request clears on wake
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_mode_r <= `PMBS_MODE_NORMAL;
      ana_r      <= `PMBS_ANALOG_RST;
    end else begin
      if (wr_mode)
        req_mode_r <= hwdata[1:0];
      else if (idle_exit)
        req_mode_r <= `PMBS_MODE_NORMAL;
      if (wr_ana)
        ana_r <= hwdata[3:0];
    end
  end

  // sticky wake flag: set wins over a software clear
  assign wake_irq_nxt = idle_exit | (wake_irq_r & ~(wr_wake & hwdata[0]));
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      wake_irq_r <= 1'b0;
    else
      wake_irq_r <= wake_irq_nxt;
  end

  // power state machine; arm waits for the writing instruction to retire
  assign idle_exit = (state_r == PMBS_ST_IDLE) & irq_pending;
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      PMBS_ST_RUN:
        if (wr_mode && hwdata[1:0] != `PMBS_MODE_NORMAL)
          state_nxt = PMBS_ST_ARM;
      PMBS_ST_ARM:
        if (instr_done) begin
          if (req_mode_r == `PMBS_MODE_PDOWN)
            state_nxt = PMBS_ST_PDOWN;
          else if (req_mode_r == `PMBS_MODE_IDLE)
            state_nxt = PMBS_ST_IDLE;
          else
            state_nxt = PMBS_ST_RUN;
        end
      PMBS_ST_IDLE:
        if (irq_pending)
          state_nxt = PMBS_ST_RUN;
      PMBS_ST_PDOWN:
        state_nxt = PMBS_ST_PDOWN;
      default:
        state_nxt = PMBS_ST_RUN;
    endcase
  end

  // clock, pin and converter control per state
  always_comb begin
    power_nxt = '0;
    power_nxt.osc_en        = (state_nxt != PMBS_ST_PDOWN);
    power_nxt.periph_clk_en = (state_nxt != PMBS_ST_PDOWN);
    power_nxt.core_clk_en   = (state_nxt == PMBS_ST_RUN) || (state_nxt == PMBS_ST_ARM);
    power_nxt.hold_ports    = (state_nxt == PMBS_ST_IDLE) || (state_nxt == PMBS_ST_PDOWN);
    power_nxt.dac_hold      = (state_nxt == PMBS_ST_IDLE);
    power_nxt.dac_hiz       = (state_nxt == PMBS_ST_PDOWN);
  end

  // analog enables; all off in power-down
  always_comb begin
    analog_nxt         = '0;
    analog_nxt.adc_en  = ana_r[`PMBS_ANA_ADC];
    analog_nxt.dac_en  = ana_r[`PMBS_ANA_DAC1:`PMBS_ANA_DAC0];
    analog_nxt.vref_en = ana_r[`PMBS_ANA_VREF] | ana_r[`PMBS_ANA_ADC] | ana_r[`PMBS_ANA_DAC0] | ana_r[`PMBS_ANA_DAC1];
    if (state_nxt == PMBS_ST_PDOWN)
      analog_nxt = '0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r  <= PMBS_ST_RUN;
      power_r  <= 6'h18;
      analog_r <= '0;
    end else begin
      state_r  <= state_nxt;
      power_r  <= power_nxt;
      analog_r <= analog_nxt;
    end
  end
  assign power  = power_r;
  assign analog = analog_r;

  // boot strap caught at the first edge after reset release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      boot_taken_r <= 1'b0;
      download_r   <= 1'b0;
      strobe_oe_r  <= 1'b0;
    end else begin
      boot_taken_r <= 1'b1;
      strobe_oe_r  <= 1'b1;
      if (!boot_taken_r)
        download_r <= ~strobe_in;
    end
  end
  assign download_mode  = download_r;
  assign uart_loader_en = download_r;
  assign strobe_oe      = strobe_oe_r;

  // strobe used for fetches only once the pin is driven
  pmbs_strobe u_strobe (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .enable   (boot_taken_r & power_nxt.core_clk_en),
    .fetch_req(fetch_req),
    .strobe_n (fetch_strobe_n)
  );
  assign strobe_out = fetch_strobe_n;

  // checks: named steps of the mode sequence
  sequence s_arm_idle;
    state_r == PMBS_ST_ARM && instr_done && req_mode_r == `PMBS_MODE_IDLE;
  endsequence
  sequence s_arm_pdown;
    state_r == PMBS_ST_ARM && instr_done && req_mode_r == `PMBS_MODE_PDOWN;
  endsequence
  sequence s_mode_go;
    state_r == PMBS_ST_RUN && wr_mode && hwdata[1:0] != `PMBS_MODE_NORMAL;
  endsequence
  sequence s_wake_event;
    idle_exit && !wr_mode;
  endsequence

  // checks: idle mode; an interrupt in the first idle cycle is legal, so gating is seen at once
  a_idle_core_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    s_arm_idle |=> state_r == PMBS_ST_IDLE && !power.core_clk_en && power.osc_en)
    else $error("idle gating wrong");
  a_idle_periph_clk: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == PMBS_ST_IDLE |-> power.periph_clk_en)
    else $error("periph clock lost in idle");
  a_idle_hold_pins: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == PMBS_ST_IDLE |-> power.hold_ports && power.dac_hold && !power.dac_hiz)
    else $error("idle pin hold");
  a_idle_wake_irq: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == PMBS_ST_IDLE && irq_pending |=> state_r == PMBS_ST_RUN ##1 power.core_clk_en)
    else $error("no wake");
  a_idle_no_wake: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == PMBS_ST_IDLE && !irq_pending |=> state_r == PMBS_ST_IDLE && !power.core_clk_en)
    else $error("idle left without interrupt");
  a_strobe_idle: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == PMBS_ST_IDLE && !irq_pending |=> strobe_out)
    else $error("fetch strobe while core gated");

  // checks: power-down; only the reset line can bring the chip back
  a_pdown_stop_osc: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == PMBS_ST_PDOWN |-> !power.osc_en && !power.periph_clk_en && analog == '0)
    else $error("pdown osc");
  a_pdown_dac_hiz: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == PMBS_ST_PDOWN |-> power.dac_hiz && power.hold_ports)
    else $error("pdown pins");
  a_dac_hiz_only: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r != PMBS_ST_PDOWN |-> !power.dac_hiz)
    else $error("converter outputs floated outside pdown");
  a_pdown_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == PMBS_ST_PDOWN |=> state_r == PMBS_ST_PDOWN)
    else $error("left pdown");
  a_pdown_no_irq: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == PMBS_ST_PDOWN && irq_pending |=> state_r == PMBS_ST_PDOWN && !power.core_clk_en)
    else $error("interrupt woke pdown");
  a_strobe_pdown: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == PMBS_ST_PDOWN |=> strobe_out)
    else $error("fetch strobe in pdown");

  // checks: mode requests; entry always passes through the arm state
  a_arm_on_write: assert property (@(posedge hclk) disable iff (!hresetn)
    s_mode_go |=> state_r == PMBS_ST_ARM)
    else $error("mode write not armed");
  a_normal_stays: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == PMBS_ST_RUN && !(wr_mode && hwdata[1:0] != `PMBS_MODE_NORMAL) |=> state_r == PMBS_ST_RUN)
    else $error("run left without request");
  a_mode_reg_write: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_mode |=> req_mode_r == $past(hwdata[1:0]))
    else $error("mode write lost");
  a_mode_waits: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == PMBS_ST_ARM && !instr_done |=> state_r == PMBS_ST_ARM)
    else $error("mode before retire");
  a_pdown_entry: assert property (@(posedge hclk) disable iff (!hresetn)
    s_arm_pdown |=> state_r == PMBS_ST_PDOWN && power.dac_hiz && !power.osc_en)
    else $error("pdown entry wrong");
  a_core_runs: assert property (@(posedge hclk) disable iff (!hresetn)
    boot_taken_r && (state_r == PMBS_ST_RUN || state_r == PMBS_ST_ARM) |-> power.core_clk_en && !power.hold_ports)
    else $error("core not running in normal mode");
  a_periph_run: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r != PMBS_ST_PDOWN |-> power.periph_clk_en && power.osc_en)
    else $error("oscillator stopped outside pdown");

  // checks: wake flag and request clear; set beats a clear in the same cycle
  a_wake_clears_req: assert property (@(posedge hclk) disable iff (!hresetn)
    s_wake_event |=> req_mode_r == `PMBS_MODE_NORMAL && wake_irq_r)
    else $error("wake did not clear request");
  a_wake_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    wake_irq_r && wr_wake && hwdata[0] && !idle_exit |=> !wake_irq_r)
    else $error("wake flag clear lost");
  a_rd_capture: assert property (@(posedge hclk) disable iff (!hresetn)
    addr_ok && !hwrite |=> hrdata == $past(rd_mux))
    else $error("read data not captured");

  // checks: converter enables; the reference follows demand, not only its own bit
  a_ana_write: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_ana |=> ana_r == $past(hwdata[3:0]))
    else $error("analog write lost");
  a_analog_follow: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r != PMBS_ST_PDOWN |->
      analog.adc_en == $past(ana_r[`PMBS_ANA_ADC]) && analog.dac_en == $past(ana_r[`PMBS_ANA_DAC1:`PMBS_ANA_DAC0]))
    else $error("converter enable mismatch");
  a_vref_auto_on: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r != PMBS_ST_PDOWN && (analog.adc_en || analog.dac_en != 2'h0) |-> analog.vref_en)
    else $error("vref off");
  a_vref_demand: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r != PMBS_ST_PDOWN |->
      analog.vref_en == ($past(ana_r[`PMBS_ANA_VREF]) || analog.adc_en || analog.dac_en != 2'h0))
    else $error("vref on without demand");

  // checks: boot strap; the release edge itself is skipped, its sampled values are reset ones
  a_strobe_drive: assert property (@(posedge hclk) disable iff (!hresetn)
    strobe_oe == boot_taken_r)
    else $error("strobe pin drive wrong");
  a_boot_capture: assert property (@(posedge hclk) disable iff (!hresetn)
    hresetn && !boot_taken_r |=> download_r == !$past(strobe_in))
    else $error("strap not captured");
  a_boot_stable: assert property (@(posedge hclk) disable iff (!hresetn)
    boot_taken_r |=> $stable(download_r))
    else $error("boot mode changed");
  a_loader_same: assert property (@(posedge hclk) disable iff (!hresetn)
    uart_loader_en == download_mode)
    else $error("loader and debug entry differ");
  a_strobe_fetch: assert property (@(posedge hclk) disable iff (!hresetn)
    !fetch_req |=> strobe_out)
    else $error("strobe without fetch");
endmodule
`default_nettype wire

// ==== dv/pmbs_strap_model.sv ====
// download-select jumper and pin pull on the program strobe pin
// assumes the device drives the pin whenever strobe_oe is high
`timescale 1ns/10ps
`default_nettype none
module pmbs_strap_model (
  input  wire logic jumper_on,
  input  wire logic strobe_out,
  input  wire logic strobe_oe,
  output var  logic strobe_in
);
  // device drive beats the 1k pull-down; a weak pull-up holds the idle pin high
  always_comb begin
    if (strobe_oe)
      strobe_in = strobe_out;
    else if (jumper_on)
      strobe_in = 1'b0;
    else
      strobe_in = 1'b1;
  end
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
// self-checking bench for the power-mode and boot-select block
// assumes one bus master, zero-wait slave, strap model on the strobe pin
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import pmbs_pkg::*;
  logic         hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic         instr_done = 1'b0, irq_pending = 1'b0, fetch_req = 1'b0, jumper_on = 1'b0;
  logic [31:0]  haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]   htrans = 2'h0;
  logic [2:0]   hsize = 3'h2;
  logic         hreadyout, hresp, strobe_in, strobe_out, strobe_oe, download_mode, uart_loader_en;
  pmbs_power_t  power;
  pmbs_analog_t analog;
  int           bad_count = 0, compares = 0, cyc = 0, lows;
  // rows: written analog nibble, expected enables {adc,dac1,dac0,vref}
  logic [7:0]   rows [6] = '{8'h00, 8'h19, 8'h23, 8'h45, 8'h81, 8'hff};

  always #25 hclk = ~hclk;

  pmbs_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .instr_done(instr_done), .irq_pending(irq_pending),
    .fetch_req(fetch_req), .strobe_in(strobe_in), .strobe_out(strobe_out), .strobe_oe(strobe_oe),
    .power(power), .analog(analog), .download_mode(download_mode), .uart_loader_en(uart_loader_en));
  pmbs_strap_model i_strap (.jumper_on(jumper_on), .strobe_out(strobe_out), .strobe_oe(strobe_oe),
    .strobe_in(strobe_in));

  task automatic close_out;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // one single transfer; read data taken at the closing data-phase edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic do_reset(input logic jmp);
    jumper_on <= jmp;
    hresetn <= 1'b0;
    tick(16);
    chk({strobe_oe, strobe_out}, 32'h1);
    chk(power, 32'h18);
    hresetn <= 1'b1;
    tick(3);
    chk({download_mode, uart_loader_en}, {30'h0, jmp, jmp});
    chk(strobe_oe, 32'h1);
    chk(power, 32'h38);
    chk({hreadyout, hresp}, 32'h2);
  endtask

  // mode write must wait for the writing instruction to retire
  task automatic enter(input logic [31:0] m);
    xfer(1'b1, 8'h00, m);
    tick(2);
    chk(power, 32'h38);
    xfer(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h21);
    xfer(1'b0, 8'h00, 32'h0);
    chk(rd, m);
    instr_done <= 1'b1;
    @(posedge hclk);
    instr_done <= 1'b0;
    tick(3);
  endtask

  task automatic count_low(input int n);
    lows = 0;
    repeat (n) begin
      @(posedge hclk);
      lows += int'(strobe_out === 1'b0);
    end
  endtask

  // hang guard, well above the under two hundred cycles the run needs
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      close_out();
    end
  end

  initial begin
    do_reset(1'b0);
    foreach (rows[i]) begin
      xfer(1'b1, 8'h04, {28'h0, rows[i][7:4]});
      tick(2);
      chk(analog, {28'h0, rows[i][3:0]});
    end
    fetch_req <= 1'b1;
    tick(6);
    count_low(24);
    chk(32'(lows), 32'd12);
    fetch_req <= 1'b0;
    tick(8);
    count_low(12);
    chk(32'(lows), 32'd0);
    enter(32'h1);
    chk(power, 32'h1e);
    chk(analog, 32'hf);
    xfer(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h23);
    irq_pending <= 1'b1;
    tick(3);
    irq_pending <= 1'b0;
    chk(power, 32'h38);
    xfer(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h1);
    xfer(1'b1, 8'h0c, 32'h1);
    xfer(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h0);
    xfer(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    enter(32'h2);
    chk(power, 32'h05);
    chk(analog, 32'h0);
    irq_pending <= 1'b1;
    tick(4);
    xfer(1'b0, 8'h08, 32'h0);
    chk(rd & 32'h13, 32'h02);
    chk(power, 32'h05);
    irq_pending <= 1'b0;
    do_reset(1'b1);
    xfer(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h10);
    close_out();
  end
endmodule
`default_nettype wire
